/* logic/pse_pkg.sv */
// Package for the supply status, enable and mode register bank.
// Assumes a single 20 MHz clock; imported by the bank only, the bench uses literal values.
package pse_pkg;

	// Target address on the two-wire serial bus
	localparam logic [6:0] PSE_TARGET_ADDR   = 7'h48;

	// Register offsets
	localparam logic [7:0] PSE_OFS_STATUS    = 8'h01;
	localparam logic [7:0] PSE_OFS_MASK      = 8'h02;
	localparam logic [7:0] PSE_OFS_ENABLE    = 8'h03;
	localparam logic [7:0] PSE_OFS_MODE      = 8'h04;

	// Reset values, loaded by undervoltage lockout, and the unmapped read value
	localparam logic [7:0] PSE_RST_MASK      = 8'hC0;
	localparam logic [7:0] PSE_RST_ENABLE    = 8'hFF;
	localparam logic [7:0] PSE_RST_MODE      = 8'hB1;
	localparam logic [7:0] PSE_UNMAPPED_DATA = 8'hFF;

	// Field positions shared by status, mask and enable
	localparam int PSE_BIT_PWRFAIL = 7;
	localparam int PSE_BIT_LOWBATT = 6;
	localparam int PSE_BIT_BUCK1   = 5;
	localparam int PSE_BIT_BUCK2   = 4;
	localparam int PSE_BIT_BUCK3   = 3;
	localparam int PSE_BIT_LIN2    = 2;
	localparam int PSE_BIT_LIN1    = 1;

	// Writable bits of mask and enable registers
	localparam logic [7:0] PSE_MASK_WMASK    = 8'hFE;
	localparam logic [7:0] PSE_ENABLE_WMASK  = 8'h3E;

	// Converter mode fields
	localparam int PSE_MODE_BUCK2_PH_LSB = 6;
	localparam int PSE_MODE_BUCK3_PH_LSB = 4;
	localparam int PSE_MODE_LOW_RIPPLE   = 3;
	localparam int PSE_MODE_FORCED_FIXED_FREQUENCY_BUCK2   = 2;
	localparam int PSE_MODE_FORCED_FIXED_FREQUENCY_BUCK1   = 1;
	localparam int PSE_MODE_FORCED_FIXED_FREQUENCY_BUCK3   = 0;
	localparam logic [1:0] PSE_BUCK1_PHASE = 2'h0;

	// Serial engine states
	typedef enum logic [3:0] {
		PSE_ST_IDLE     = 4'b0000,
		PSE_ST_ADDR     = 4'b0001,
		PSE_ST_ADDR_ACK = 4'b0010,
		PSE_ST_PTR      = 4'b0011,
		PSE_ST_PTR_ACK  = 4'b0100,
		PSE_ST_WDATA    = 4'b0101,
		PSE_ST_WR_ACK   = 4'b0110,
		PSE_ST_RDATA    = 4'b0111,
		PSE_ST_HOST_ACK = 4'b1000
	} pse_state_e;

endpackage

/* logic/pse_regs.sv */
// Supply fault status, alert mask, supply enable and converter mode registers,
// reached by a host as a target on the two-wire serial bus.
// Assumes serial pins already synchronous to clk_i; the pad resolves the
// open-drain data line from sda_oe_o. reset_i stands for undervoltage lockout.
`timescale 1ns/1ns

module pse_regs
	import pse_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// Serial bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Comparator and supply monitor inputs
	input  wire logic       power_fail_sense_below_i,
	input  wire logic       low_battery_sense_below_i,
	input  wire logic       buck1_below_i,
	input  wire logic       buck2_below_i,
	input  wire logic       buck3_below_i,
	input  wire logic       linear_reg2_below_i,
	input  wire logic       linear_reg1_below_i,
	input  wire logic       dynamic_voltage_transition_i,
	// External enable pins
	input  wire logic       buck1_enable_pin_i,
	input  wire logic       buck2_enable_pin_i,
	input  wire logic       buck3_enable_pin_i,
	input  wire logic       linear_enable_pin_i,
	// Supply enables
	output logic            buck1_on_o,
	output logic            buck2_on_o,
	output logic            buck3_on_o,
	output logic            linear_reg2_on_o,
	output logic            linear_reg1_on_o,
	// Converter mode controls
	output logic [1:0]      buck1_phase_o,
	output logic [1:0]      buck2_phase_o,
	output logic [1:0]      buck3_phase_o,
	output logic            low_ripple_o,
	output logic            buck1_forced_fixed_frequency_o,
	output logic            buck2_forced_fixed_frequency_o,
	output logic            buck3_forced_fixed_frequency_o,
	// Fault alert, active low
	output logic            fault_alert_n_o
);

	pse_state_e  state_reg;
	logic        scl_q_reg;
	logic        sda_q_reg;
	logic [3:0]  bits_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  ptr_reg;
	logic        host_nack_reg;
	logic        sda_oe_reg;
	logic        wr_stb;
	logic        rd_status_stb;
	logic [7:0]  status_reg;
	logic [7:0]  mask_reg;
	logic [7:0]  enable_reg;
	logic [7:0]  mode_reg;
	logic [7:0]  block_reg;
	logic [7:0]  enable_next;
	logic [7:0]  rd_data;
	logic [7:0]  pin_low;
	logic        start_seen;
	logic        stop_seen;
	logic        scl_rise;
	logic        scl_fall;

	// Bus conditions from the previous sample of each line
	assign start_seen = scl_i && scl_q_reg && sda_q_reg && !sda_i;
	assign stop_seen  = scl_i && scl_q_reg && !sda_q_reg && sda_i;
	assign scl_rise   = scl_i && !scl_q_reg;
	assign scl_fall   = !scl_i && scl_q_reg;

	// Line history
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_q_reg <= scl_i;
			sda_q_reg <= sda_i;
		end
	end

	// Read data selection; unused addresses answer all ones
	always_comb begin
		case (ptr_reg)
			PSE_OFS_STATUS: rd_data = status_reg;
			PSE_OFS_MASK:   rd_data = mask_reg;
			PSE_OFS_ENABLE: rd_data = enable_reg;
			PSE_OFS_MODE:   rd_data = mode_reg;
			default:        rd_data = PSE_UNMAPPED_DATA;
		endcase
	end

	// Serial target engine; data is shifted on SCL rise and driven after SCL fall
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg     <= PSE_ST_IDLE;
			bits_reg      <= 4'h0;
			shift_reg     <= 8'h00;
			ptr_reg       <= 8'h00;
			host_nack_reg <= 1'b0;
			sda_oe_reg    <= 1'b0;
		end else if (start_seen) begin
			state_reg  <= PSE_ST_ADDR;
			bits_reg   <= 4'h0;
			sda_oe_reg <= 1'b0;
		end else if (stop_seen) begin
			state_reg  <= PSE_ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				PSE_ST_ADDR, PSE_ST_PTR, PSE_ST_WDATA, PSE_ST_RDATA: begin
					shift_reg <= {shift_reg[6:0], sda_i};
					bits_reg  <= bits_reg + 4'h1;
				end
				PSE_ST_HOST_ACK: host_nack_reg <= sda_i;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				PSE_ST_ADDR: begin
					if (bits_reg == 4'h8 && shift_reg[7:1] == PSE_TARGET_ADDR) begin
						state_reg  <= PSE_ST_ADDR_ACK;
						sda_oe_reg <= 1'b1;
					end else if (bits_reg == 4'h8) begin
						state_reg <= PSE_ST_IDLE;
					end
				end
				PSE_ST_ADDR_ACK: begin
					bits_reg <= 4'h0;
					if (shift_reg[0]) begin
						state_reg  <= PSE_ST_RDATA;
						shift_reg  <= rd_data;
						sda_oe_reg <= !rd_data[7];
					end else begin
						state_reg  <= PSE_ST_PTR;
						sda_oe_reg <= 1'b0;
					end
				end
				PSE_ST_PTR: begin
					if (bits_reg == 4'h8) begin
						ptr_reg    <= shift_reg;
						state_reg  <= PSE_ST_PTR_ACK;
						sda_oe_reg <= 1'b1;
					end
				end
				PSE_ST_WDATA: begin
					if (bits_reg == 4'h8) begin
						state_reg  <= PSE_ST_WR_ACK;
						sda_oe_reg <= 1'b1;
					end
				end
				PSE_ST_PTR_ACK, PSE_ST_WR_ACK: begin
					state_reg  <= PSE_ST_WDATA;
					bits_reg   <= 4'h0;
					sda_oe_reg <= 1'b0;
				end
				PSE_ST_RDATA: begin
					if (bits_reg == 4'h8) begin
						state_reg  <= PSE_ST_HOST_ACK;
						sda_oe_reg <= 1'b0;
					end else begin
						sda_oe_reg <= !shift_reg[7];
					end
				end
				PSE_ST_HOST_ACK: begin
					// A host that withholds its ack ends the read; the line stays released
					if (host_nack_reg) begin
						state_reg <= PSE_ST_IDLE;
					end else begin
						state_reg  <= PSE_ST_RDATA;
						bits_reg   <= 4'h0;
						shift_reg  <= rd_data;
						sda_oe_reg <= !rd_data[7];
					end
				end
				default: sda_oe_reg <= 1'b0;
			endcase
		end
	end

	// Write strobe as the data ack begins; status fetch as a read byte is loaded
	assign wr_stb = scl_fall && !start_seen && !stop_seen
		&& state_reg == PSE_ST_WDATA && bits_reg == 4'h8;
	assign rd_status_stb = scl_fall && !start_seen && !stop_seen
		&& ptr_reg == PSE_OFS_STATUS
		&& ((state_reg == PSE_ST_ADDR_ACK && shift_reg[0])
		|| (state_reg == PSE_ST_HOST_ACK && !host_nack_reg));

	// Open drain: only ever pulls low
	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_oe_reg;

	// Live supply status, captured every cycle; writes never reach it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			status_reg <= 8'h00;
		end else begin
			status_reg[PSE_BIT_PWRFAIL] <= power_fail_sense_below_i;
			status_reg[PSE_BIT_LOWBATT] <= low_battery_sense_below_i;
			status_reg[PSE_BIT_BUCK1]   <= buck1_below_i && buck1_on_o;
			status_reg[PSE_BIT_BUCK2]   <= buck2_below_i && buck2_on_o;
			status_reg[PSE_BIT_BUCK3]   <= buck3_below_i && buck3_on_o
				&& !dynamic_voltage_transition_i;
			status_reg[PSE_BIT_LIN2]    <= linear_reg2_below_i && linear_reg2_on_o;
			status_reg[PSE_BIT_LIN1]    <= linear_reg1_below_i && linear_reg1_on_o;
			status_reg[0]               <= 1'b0;
		end
	end

	// Alert mask; bit 0 keeps its default
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mask_reg <= PSE_RST_MASK;
		end else if (wr_stb && ptr_reg == PSE_OFS_MASK) begin
			mask_reg <= (shift_reg & PSE_MASK_WMASK)
				| (PSE_RST_MASK & ~PSE_MASK_WMASK);
		end
	end

	// Enable pins low, per bit position
	always_comb begin
		pin_low                = 8'h00;
		pin_low[PSE_BIT_BUCK1] = !buck1_enable_pin_i;
		pin_low[PSE_BIT_BUCK2] = !buck2_enable_pin_i;
		pin_low[PSE_BIT_BUCK3] = !buck3_enable_pin_i;
		pin_low[PSE_BIT_LIN2]  = !linear_enable_pin_i;
		pin_low[PSE_BIT_LIN1]  = !linear_enable_pin_i;
	end

	// A low pin wins over a host write in the same cycle
	always_comb begin
		enable_next = enable_reg;
		if (wr_stb && ptr_reg == PSE_OFS_ENABLE) begin
			enable_next = (shift_reg & PSE_ENABLE_WMASK)
				| (PSE_RST_ENABLE & ~PSE_ENABLE_WMASK);
		end
		enable_next = enable_next | pin_low;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			enable_reg <= PSE_RST_ENABLE;
		end else begin
			enable_reg <= enable_next;
		end
	end

	// Supply switching: register bit AND pin
	assign buck1_on_o       = enable_reg[PSE_BIT_BUCK1] && buck1_enable_pin_i;
	assign buck2_on_o       = enable_reg[PSE_BIT_BUCK2] && buck2_enable_pin_i;
	assign buck3_on_o       = enable_reg[PSE_BIT_BUCK3] && buck3_enable_pin_i;
	assign linear_reg2_on_o = enable_reg[PSE_BIT_LIN2] && linear_enable_pin_i;
	assign linear_reg1_on_o = enable_reg[PSE_BIT_LIN1] && linear_enable_pin_i;

	// Converter mode
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mode_reg <= PSE_RST_MODE;
		end else if (wr_stb && ptr_reg == PSE_OFS_MODE) begin
			mode_reg <= shift_reg;
		end
	end

	// Buck1 is the reference, so its phase has no setting
	assign buck1_phase_o = PSE_BUCK1_PHASE;
	assign buck2_phase_o = mode_reg[PSE_MODE_BUCK2_PH_LSB +: 2];
	assign buck3_phase_o = mode_reg[PSE_MODE_BUCK3_PH_LSB +: 2];
	assign low_ripple_o  = mode_reg[PSE_MODE_LOW_RIPPLE];
	assign buck2_forced_fixed_frequency_o = mode_reg[PSE_MODE_FORCED_FIXED_FREQUENCY_BUCK2];
	assign buck1_forced_fixed_frequency_o = mode_reg[PSE_MODE_FORCED_FIXED_FREQUENCY_BUCK1];
	assign buck3_forced_fixed_frequency_o = mode_reg[PSE_MODE_FORCED_FIXED_FREQUENCY_BUCK3];

	// Read blocking: bits seen by a status read stay off the pin until they drop,
	// so a fault that clears and returns alerts again
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			block_reg <= 8'h00;
		end else if (rd_status_stb) begin
			block_reg <= status_reg;
		end else begin
			block_reg <= block_reg & status_reg;
		end
	end

	// Alert pin, driven low while any unmasked, unblocked fault stands
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fault_alert_n_o <= 1'b1;
		end else begin
			fault_alert_n_o <= ~|(status_reg & ~mask_reg & ~block_reg);
		end
	end

endmodule

/* sim/pse_regs_monitor.sv */
// Checker for the supply status, enable and mode bank, bound to its top module.
// Sees only the bank's ports; one clock, reset stands for undervoltage lockout.
`timescale 1ns/1ns
module pse_regs_monitor (
	// Clock and lockout
	input wire logic       clk_i, reset_i,
	// Monitors and enable pins
	input wire logic       power_fail_sense_below_i, low_battery_sense_below_i,
	input wire logic       buck1_below_i, buck2_below_i, buck3_below_i,
	input wire logic       linear_reg2_below_i, linear_reg1_below_i,
	input wire logic       dynamic_voltage_transition_i,
	input wire logic       buck1_enable_pin_i, buck2_enable_pin_i,
	input wire logic       buck3_enable_pin_i, linear_enable_pin_i,
	// Outputs under watch
	input wire logic       buck1_on_o, buck2_on_o, buck3_on_o,
	input wire logic       linear_reg2_on_o, linear_reg1_on_o,
	input wire logic [1:0] buck1_phase_o, buck2_phase_o, buck3_phase_o,
	input wire logic       low_ripple_o, fault_alert_n_o,
	input wire logic       buck1_forced_fixed_frequency_o,
	input wire logic       buck2_forced_fixed_frequency_o,
	input wire logic       buck3_forced_fixed_frequency_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Every fault quiet but buck3, so a core transition alone decides the pin
	wire quiet = !(power_fail_sense_below_i || low_battery_sense_below_i || buck1_below_i
		|| buck2_below_i || linear_reg2_below_i || linear_reg1_below_i);
	// Pin pulled low, then back high
	sequence pin2_pulse;
		!buck2_enable_pin_i ##1 buck2_enable_pin_i;
	endsequence
	a_buck1_phase_zero: assert property (buck1_phase_o == 2'h0)
		else $error("buck1 phase offset not zero");
	a_buck3_pin_gate: assert property (!buck3_enable_pin_i |-> !buck3_on_o)
		else $error("buck3 on with its pin low");
	a_linear_pin_gate: assert property (
		!linear_enable_pin_i |-> !linear_reg1_on_o && !linear_reg2_on_o)
		else $error("linear supply on with its pin low");
	a_pin_restore: assert property (pin2_pulse |-> buck2_on_o)
		else $error("buck2 not back on after pin pulse");
	a_lockout_enables: assert property ($fell(reset_i) |->
		buck1_on_o == buck1_enable_pin_i && buck3_on_o == buck3_enable_pin_i)
		else $error("supplies do not follow pins after lockout");
	a_mode_reset: assert property ($fell(reset_i) |-> {buck2_phase_o,
		buck3_phase_o, low_ripple_o, buck2_forced_fixed_frequency_o,
		buck1_forced_fixed_frequency_o, buck3_forced_fixed_frequency_o} == 8'hB1)
		else $error("mode outputs wrong after lockout");
	a_alert_unmasked: assert property ($fell(reset_i) ##0
		(buck1_below_i && buck1_on_o) [*3] |=> !fault_alert_n_o)
		else $error("unmasked buck1 fault missing on alert");
	a_transition_hides: assert property (
		(dynamic_voltage_transition_i && quiet) [*3] |=> fault_alert_n_o)
		else $error("alert during core transition");
endmodule
bind pse_regs pse_regs_monitor u_monitor (.*);

/* sim/pse_host.sv */
// Host model: two-wire bus master with 4-cycle clock phases.
// Assumes the bench resolves the open-drain data line into sda_i.
`timescale 1ns/1ns
module pse_host (
	// Clock and resolved data line
	input  wire logic clk_i,
	input  wire logic sda_i,
	// Bus drive, 1 releases the line
	output logic      scl_o,
	output logic      sda_o
);
	// Bus idles high
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic hp();
		repeat (4) @(posedge clk_i);
	endtask
	// Data moves one cycle after the clock falls, never while it is high
	task automatic bt(input logic b, output logic r);
		@(posedge clk_i) sda_o <= b;
		hp();
		scl_o <= 1'b1;
		hp();
		r = sda_i;
		scl_o <= 1'b0;
	endtask
	// Byte MSB first, then the ninth bit
	task automatic by(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], q[i]);
		end
		bt(a, r);
		k = !r;
	endtask
	// Start or repeated start
	task automatic st();
		@(posedge clk_i) sda_o <= 1'b1;
		hp();
		scl_o <= 1'b1;
		hp();
		sda_o <= 1'b0;
		hp();
		scl_o <= 1'b0;
	endtask
	task automatic sp();
		@(posedge clk_i) sda_o <= 1'b0;
		hp();
		scl_o <= 1'b1;
		hp();
		sda_o <= 1'b1;
		hp();
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic ok);
		logic [7:0] x;
		logic       k1, k2, k3;
		st();
		by({a, 1'b0}, 1'b1, x, k1);
		by(p, 1'b1, x, k2);
		by(d, 1'b1, x, k3);
		sp();
		ok = k1 & k2 & k3;
	endtask
	// Single read with a closing nack, so the target releases the line
	task automatic rd(input logic [7:0] p, output logic [7:0] q);
		logic [7:0] x;
		logic       k;
		st();
		by(8'h90, 1'b1, x, k);
		by(p, 1'b1, x, k);
		st();
		by(8'h91, 1'b1, x, k);
		by(8'hFF, 1'b1, q, k);
		sp();
	endtask
endmodule

/* sim/pse_regs_tb_top.sv */
// Bench for the status, enable and mode bank with an integer register model.
// Assumes the host model and the bound monitor are compiled alongside.
`timescale 1ns/1ns
module pse_regs_tb_top;
	logic       clk_i, reset_i, dvt, ok, scl, hsda, lr, f1, f2, f3, al_n, oe, sdo;
	logic [6:0] blw;
	logic [3:0] pin;
	logic [4:0] on;
	logic [1:0] ph1, ph2, ph3;
	logic [7:0] q, md;
	int         errors, total_checks, cyc, seed, mask_m, en_m;
	// Open-drain line: low when either side pulls it, otherwise the pull-up wins
	wire        sda = hsda & !(oe && !sdo);
	pse_host u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
	pse_regs dut (.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sdo), .sda_oe_o(oe), .power_fail_sense_below_i(blw[6]),
		.low_battery_sense_below_i(blw[5]), .buck1_below_i(blw[4]),
		.buck2_below_i(blw[3]), .buck3_below_i(blw[2]), .linear_reg2_below_i(blw[1]),
		.linear_reg1_below_i(blw[0]), .dynamic_voltage_transition_i(dvt),
		.buck1_enable_pin_i(pin[3]), .buck2_enable_pin_i(pin[2]),
		.buck3_enable_pin_i(pin[1]), .linear_enable_pin_i(pin[0]),
		.buck1_on_o(on[4]), .buck2_on_o(on[3]), .buck3_on_o(on[2]),
		.linear_reg2_on_o(on[1]), .linear_reg1_on_o(on[0]), .buck1_phase_o(ph1),
		.buck2_phase_o(ph2), .buck3_phase_o(ph3), .low_ripple_o(lr),
		.buck1_forced_fixed_frequency_o(f1), .buck2_forced_fixed_frequency_o(f2),
		.buck3_forced_fixed_frequency_o(f3), .fault_alert_n_o(al_n));
	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Cycle ceiling, well above the longest expected run
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			test_done();
		end
	end
	function automatic logic [4:0] on_e();
		return en_m[5:1] & {pin[3:1], pin[0], pin[0]};
	endfunction
	function automatic logic [7:0] st_e();
		return {blw[6:5], blw[4:0] & on_e() & {2'b11, !dvt, 2'b11}, 1'b0};
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Alert seen by the model; a blocked read forces it idle
	task automatic ca(input logic b);
		chk({7'h0, al_n}, {7'h0, b | !(|(st_e() & ~mask_m[7:0]))});
	endtask
	task automatic rt(input logic [7:0] p, input logic [7:0] e);
		u_host.rd(p, q);
		chk(q, e);
	endtask
	task automatic wt(input logic [7:0] p, input logic [7:0] d);
		u_host.wr(7'h48, p, d, ok);
		chk({7'h0, ok}, 8'h01);
		if (p == 8'h02) mask_m = d & 8'hFE;
		if (p == 8'h03) en_m = d & 8'h3E | 8'hC1;
	endtask
	// Wait, then fold pin-low forcing into the enable model
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		en_m = en_m | {2'b0, ~pin[3:1], ~pin[0], ~pin[0], 1'b0};
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		seed = 3953;
		reset_i <= 1'b1;
		dvt <= 1'b0;
		blw <= 7'h00;
		pin <= 4'hF;
		mask_m = 8'hC0;
		en_m = 8'hFF;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		rt(8'h02, 8'hC0);
		rt(8'h03, 8'hFF);
		rt(8'h04, 8'hB1);
		rt(8'h00, 8'hFF);
		rt(8'h05, 8'hFF);
		// Each phase code on both converters, random low bits
		for (int k = 0; k < 4; k++) begin
			md = {k[1:0], ~k[1:0], 4'($random(seed))};
			wt(8'h04, md);
			rt(8'h04, md);
			chk({ph2, ph3, lr, f2, f1, f3}, md);
			chk({6'h0, ph1}, 8'h00);
		end
		wt(8'h03, 8'h00);
		rt(8'h03, 8'hC1);
		chk({3'h0, on}, 8'h00);
		pin <= 4'b0010;
		w(3);
		pin <= 4'hF;
		w(2);
		rt(8'h03, en_m[7:0]);
		chk({3'h0, on}, {3'h0, on_e()});
		wt(8'h02, 8'hFF);
		rt(8'h02, 8'hFE);
		// Random faults and enables; status writes are dropped
		for (int k = 0; k < 6; k++) begin
			wt(8'h03, 8'($random(seed)));
			blw <= 7'($random(seed));
			dvt <= k[0];
			wt(8'h01, 8'h00);
			rt(8'h01, st_e());
			chk({3'h0, on}, {3'h0, on_e()});
		end
		blw <= 7'h04;
		dvt <= 1'b1;
		wt(8'h03, 8'hFF);
		wt(8'h02, 8'h00);
		w(5);
		ca(1'b0);
		dvt <= 1'b0;
		w(5);
		ca(1'b0);
		wt(8'h02, 8'h08);
		w(5);
		ca(1'b0);
		wt(8'h02, 8'h00);
		rt(8'h01, 8'h08);
		w(5);
		ca(1'b1);
		blw <= 7'h00;
		w(5);
		blw <= 7'h04;
		w(5);
		ca(1'b0);
		u_host.wr(7'h49, 8'h03, 8'h00, ok);
		chk({7'h0, ok}, 8'h00);
		rt(8'h03, 8'hFF);
		// Lockout in mid-run while buck1 is out of regulation
		blw <= 7'h10;
		wt(8'h04, 8'h00);
		reset_i <= 1'b1;
		w(3);
		reset_i <= 1'b0;
		mask_m = 8'hC0;
		en_m = 8'hFF;
		w(6);
		ca(1'b0);
		rt(8'h02, 8'hC0);
		rt(8'h03, 8'hFF);
		rt(8'h04, 8'hB1);
		test_done();
	end
endmodule
